// file: rtl/pwo_top.sv
// pwo_top.sv: channel 0 output reference of a PWM timer, with an APB
// register slave, timer run control and compare value preload.
// assumes: pclk 100 MHz, APB master in pclk domain, trigger pin async.
//
// Behaviour
// - run bit 0 stops the counter and idles logic, except single/slave trigger
// - single pulse or slave trigger mode lets hardware set the run bit
// - output mode is bit 8 on top of bits 2..0
// - codes 0000..0011: keep, drive 0, drive 1, toggle on match
// - code 0100 forces 0, code 0101 forces 1
// - pwm1: up and below compare active; down and above inactive
// - pwm2: up and below compare inactive; down and above active
// - asym pwm1: up below compare active; down above asym inactive
// - asym pwm2: up below compare inactive; down above asym active
// - select 00 edge-aligned by direction; others centre-aligned up/down
`timescale 1ns/1ps
`include "pwo_cfg.svh"

module pwo_top #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// trigger input pin
	input  wire logic        trig_in,
	// channel output
	output logic             chan0_output_reference
);

	// =================================================================
	// configuration registers
	logic [31:0]      cntcfg_ff;
	logic [31:0]      mdcfg_ff;
	logic             timer_run_bit_ff;
	logic [WIDTH-1:0] reload_ff;
	logic [8:0]       ocfg_ff;
	logic [WIDTH-1:0] chan0_compare_value_ff;
	logic [WIDTH-1:0] cmp_preload_ff;
	logic [WIDTH-1:0] chan0_asym_compare_value_ff;
	logic             oref_ff;
	logic             imm_hold_ff;
	logic             match_seen_ff;
	logic [2:0]       trig_sync_ff;
	logic             sw_trig_ff;
	pwo_pkg::pwo_state_t state_ff;
	pwo_pkg::pwo_state_t nxt_state;

	// counter
	logic [WIDTH-1:0] counter_value;
	logic             counting_down;
	logic             wrap;

	// =================================================================
	// apb decode
	// full 12-bit compare, so aliases of a register answer with an error
	wire        acc      = psel && penable;
	wire        wr       = acc && pwrite;
	wire        hit_cnt  = (paddr == `PWO_OFS_CNTCFG);
	wire        hit_md   = (paddr == `PWO_OFS_MDCFG);
	wire        hit_ctl  = (paddr == `PWO_OFS_CTRL);
	wire        hit_evg  = (paddr == `PWO_OFS_EVGEN);
	wire        hit_ctr  = (paddr == `PWO_OFS_CNT);
	wire        hit_rld  = (paddr == `PWO_OFS_RELOAD);
	wire        hit_oc   = (paddr == `PWO_OFS_CH0OCFG);
	wire        hit_cmp  = (paddr == `PWO_OFS_CH0CMP);
	wire        hit_acmp = (paddr == `PWO_OFS_CH0ACMP);
	wire        hit_st   = (paddr == `PWO_OFS_STATUS);
	wire        mapped   = hit_cnt | hit_md | hit_ctl | hit_evg | hit_ctr |
		hit_rld | hit_oc | hit_cmp | hit_acmp | hit_st;

	// =================================================================
	// field decode
	wire [1:0] count_mode_select =
		cntcfg_ff[`PWO_BIT_CMS_HI:`PWO_BIT_CMS_LO];
	wire       dir_down  = cntcfg_ff[`PWO_BIT_DIR];
	wire       spm       = mdcfg_ff[`PWO_BIT_SPM];
	wire       slv_trig  = mdcfg_ff[`PWO_BIT_SLVTRIG];
	wire       chan0_immediate_active_en = ocfg_ff[`PWO_BIT_IMAE];
	wire       chan0_compare_preload_en  = ocfg_ff[`PWO_BIT_PRE];
	wire [3:0] mode_bits = {ocfg_ff[`PWO_BIT_OM3], ocfg_ff[2:0]};
	// codes missing from the table fall to the default branch: no change
	pwo_pkg::pwo_mode_t chan0_output_mode;
	assign chan0_output_mode = pwo_pkg::pwo_mode_t'(mode_bits);

	// trigger: synchronised pin rising edge or software event bit
	wire trig_pin_rise = trig_sync_ff[1] && !trig_sync_ff[2];
	wire trigger       = trig_pin_rise || sw_trig_ff;
	wire hw_start_ok   = spm || slv_trig;
	wire hw_start      = hw_start_ok && trigger && !timer_run_bit_ff;

	// single pulse stops at the next update event
	// wrap needs the run bit, so this cannot fire on a stopped timer
	wire spm_stop      = spm && wrap;

	// =================================================================
	// compare decode used by several modes
	function automatic logic pwm_level(
		input logic             down,
		input logic [WIDTH-1:0] cnt,
		input logic [WIDTH-1:0] up_cmp,
		input logic [WIDTH-1:0] dn_cmp
	);
		if (down)
			pwm_level = !(cnt > dn_cmp);
		else
			pwm_level = (cnt < up_cmp);
	endfunction

	wire sym_lvl  = pwm_level(counting_down, counter_value,
		chan0_compare_value_ff, chan0_compare_value_ff);
	wire asym_lvl = pwm_level(counting_down, counter_value,
		chan0_compare_value_ff, chan0_asym_compare_value_ff);
	wire match    = (counter_value == chan0_compare_value_ff);
	wire match_ev = match && !match_seen_ff;
	wire is_pwm   = (chan0_output_mode == pwo_pkg::PWO_OM_PWM1) ||
		(chan0_output_mode == pwo_pkg::PWO_OM_PWM2);
	// matched level of the pwm modes, used by the immediate force
	// pwm1 matches inactive (0), pwm2 active (1); other modes never force
	wire imm_lvl  = (chan0_output_mode == pwo_pkg::PWO_OM_PWM2);
	wire imm_set  = chan0_immediate_active_en && is_pwm && trigger;

	// =================================================================
	// output reference next value
	logic nxt_oref;
	always_comb begin
		nxt_oref = oref_ff;
		case (chan0_output_mode)
			pwo_pkg::PWO_OM_NOCHG:  nxt_oref = oref_ff;
			pwo_pkg::PWO_OM_MATCH0:
				if (match_ev) nxt_oref = 1'b0;
			pwo_pkg::PWO_OM_MATCH1:
				if (match_ev) nxt_oref = 1'b1;
			pwo_pkg::PWO_OM_TOGGLE:
				if (match_ev) nxt_oref = !oref_ff;
			pwo_pkg::PWO_OM_FORCE0: nxt_oref = 1'b0;
			pwo_pkg::PWO_OM_FORCE1: nxt_oref = 1'b1;
			pwo_pkg::PWO_OM_PWM1:   nxt_oref = sym_lvl;
			pwo_pkg::PWO_OM_PWM2:   nxt_oref = !sym_lvl;
			pwo_pkg::PWO_OM_APWM1:  nxt_oref = asym_lvl;
			pwo_pkg::PWO_OM_APWM2:  nxt_oref = !asym_lvl;
			default:                nxt_oref = oref_ff;
		endcase
		// forced level wins until the next wrap
		if (imm_set || (imm_hold_ff && is_pwm && !wrap))
			nxt_oref = imm_lvl;
	end

	// =================================================================
	// run state: idle, running, stopping single pulse
	// status only: the state is read back and gates nothing
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			pwo_pkg::PWO_ST_IDLE:
				if (timer_run_bit_ff) nxt_state = pwo_pkg::PWO_ST_RUN;
			pwo_pkg::PWO_ST_RUN:
				if (spm_stop) nxt_state = pwo_pkg::PWO_ST_WAIT;
				else if (!timer_run_bit_ff) nxt_state = pwo_pkg::PWO_ST_IDLE;
			pwo_pkg::PWO_ST_WAIT:   nxt_state = pwo_pkg::PWO_ST_IDLE;
			default:                nxt_state = pwo_pkg::PWO_ST_IDLE;
		endcase
	end

	// =================================================================
	// counter instance; run only while the run bit is set
	// restart serves only the slave restart mode, which is left out here
	pwo_counter #(.WIDTH(WIDTH)) u_cnt (
		.pclk              (pclk),
		.presetn           (presetn),
		.run               (timer_run_bit_ff),
		.count_mode_select (count_mode_select),
		.dir_down          (dir_down),
		.reload            (reload_ff),
		.restart           (1'b0),
		.counter_value     (counter_value),
		.counting_down     (counting_down),
		.wrap              (wrap)
	);

	// =================================================================
	// read mux; unmapped reads zero with an error
	// the event register reads as zero: its bit is a one-cycle pulse
	wire [31:0] status_w = {29'h0000_0000, counting_down, state_ff};
	wire [31:0] rd_mux =
		hit_cnt  ? cntcfg_ff :
		hit_md   ? mdcfg_ff :
		hit_ctl  ? {31'h0000_0000, timer_run_bit_ff} :
		hit_ctr  ? 32'(counter_value) :
		hit_rld  ? 32'(reload_ff) :
		hit_oc   ? {23'h00_0000, ocfg_ff} :
		hit_cmp  ? 32'(chan0_compare_value_ff) :
		hit_acmp ? 32'(chan0_asym_compare_value_ff) :
		hit_st   ? status_w : `PWO_RST_ZERO;

	// apb answer registered: one wait cycle per access
	// one wait cycle, but prdata and pslverr come straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `PWO_RST_ZERO;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata  <= rd_mux;
		end
	end

	wire wr_take = wr && pready;

	// configuration writes; reserved bits kept zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cntcfg_ff <= `PWO_RST_ZERO;
			mdcfg_ff  <= `PWO_RST_ZERO;
			ocfg_ff   <= 9'h000;
			reload_ff <= `PWO_RST_RELOAD;
			chan0_asym_compare_value_ff <= '0;
		end else if (wr_take) begin
			if (hit_cnt)  cntcfg_ff <= pwdata & 32'h0103_0000;
			if (hit_md)   mdcfg_ff  <= pwdata & 32'h0100_0100;
			if (hit_oc)   ocfg_ff   <= pwdata[8:0] & 9'h137;
			if (hit_rld)  reload_ff <= pwdata[WIDTH-1:0];
			if (hit_acmp) chan0_asym_compare_value_ff <= pwdata[WIDTH-1:0];
		end
	end

	// compare value: direct or through preload
	// a write and a wrap in one cycle: the wrap loads the older word and
	// the new one waits for the next wrap
	wire cmp_wr = wr_take && hit_cmp;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan0_compare_value_ff <= '0;
			cmp_preload_ff         <= '0;
		end else begin
			if (cmp_wr) cmp_preload_ff <= pwdata[WIDTH-1:0];
			if (cmp_wr && !chan0_compare_preload_en)
				chan0_compare_value_ff <= pwdata[WIDTH-1:0];
			else if (wrap && chan0_compare_preload_en)
				chan0_compare_value_ff <= cmp_preload_ff;
		end
	end

	// run bit: software, hardware start, single pulse stop
	// hardware start wins over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timer_run_bit_ff <= 1'b0;
		else if (hw_start)
			timer_run_bit_ff <= 1'b1;
		else if (spm_stop)
			timer_run_bit_ff <= 1'b0;
		else if (wr_take && hit_ctl)
			timer_run_bit_ff <= pwdata[`PWO_BIT_RUN];
	end

	// trigger pin synchroniser and software trigger pulse
	// bits 0 and 1 synchronise the pin; bit 2 only delays for the edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_sync_ff <= 3'b000;
			sw_trig_ff   <= 1'b0;
		end else begin
			trig_sync_ff <= {trig_sync_ff[1:0], trig_in};
			sw_trig_ff   <= wr_take && hit_evg && pwdata[`PWO_BIT_TRIG];
		end
	end

	// output reference, idle while stopped
	// single pulse and slave trigger keep it live, since a trigger may
	// start the timer before the run bit is seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oref_ff       <= 1'b0;
			imm_hold_ff   <= 1'b0;
			match_seen_ff <= 1'b0;
			state_ff      <= pwo_pkg::PWO_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
			if (timer_run_bit_ff || hw_start_ok) begin
				oref_ff       <= nxt_oref;
				match_seen_ff <= match;
				imm_hold_ff   <= imm_set || (imm_hold_ff && !wrap);
			end
		end
	end

	assign chan0_output_reference = oref_ff;

endmodule

// file: rtl/pwo_cfg.svh
// pwo_cfg.svh: register offsets, field positions, reset values for the
// channel 0 output reference block.
// assumes: included by bare name from rtl files; definitions only.
`ifndef PWO_CFG_SVH
`define PWO_CFG_SVH

// =====================================================================
// register offsets (byte addresses)
`define PWO_OFS_CNTCFG      12'h000
`define PWO_OFS_MDCFG       12'h004
`define PWO_OFS_CTRL        12'h010
`define PWO_OFS_EVGEN       12'h078
`define PWO_OFS_CNT         12'h080
`define PWO_OFS_RELOAD      12'h088
`define PWO_OFS_CH0OCFG     12'h040
`define PWO_OFS_CH0CMP      12'h090
`define PWO_OFS_CH0ACMP     12'h0A0
`define PWO_OFS_STATUS      12'h0F0

// =====================================================================
// field positions
`define PWO_BIT_DIR         24
`define PWO_BIT_CMS_HI      17
`define PWO_BIT_CMS_LO      16
`define PWO_BIT_SPM         24
`define PWO_BIT_SLVTRIG     8
`define PWO_BIT_RUN         0
`define PWO_BIT_TRIG        2
`define PWO_BIT_OM3         8
`define PWO_BIT_IMAE        5
`define PWO_BIT_PRE         4

// =====================================================================
// reset values
`define PWO_RST_ZERO        32'h0000_0000
`define PWO_RST_RELOAD      16'hFFFF

`endif

// file: rtl/pwo_pkg.sv
// pwo_pkg.sv: types shared by the channel 0 output reference block.
// assumes: compiled before every rtl module.
package pwo_pkg;

	// output mode codes of channel 0
	typedef enum logic [3:0] {
		PWO_OM_NOCHG  = 4'b0000,
		PWO_OM_MATCH0 = 4'b0001,
		PWO_OM_MATCH1 = 4'b0010,
		PWO_OM_TOGGLE = 4'b0011,
		PWO_OM_FORCE0 = 4'b0100,
		PWO_OM_FORCE1 = 4'b0101,
		PWO_OM_PWM1   = 4'b0110,
		PWO_OM_PWM2   = 4'b0111,
		PWO_OM_APWM1  = 4'b1110,
		PWO_OM_APWM2  = 4'b1111
	} pwo_mode_t;

	// counter run state
	typedef enum logic [1:0] {
		PWO_ST_IDLE = 2'b00,
		PWO_ST_RUN  = 2'b01,
		PWO_ST_WAIT = 2'b10
	} pwo_state_t;

endpackage

// file: rtl/pwo_counter.sv
// pwo_counter.sv: up/down counter with edge and centre-aligned modes.
// assumes: pclk domain, enable from the register block, no prescaler.
`timescale 1ns/1ps

module pwo_counter #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// control
	input  wire logic             run,
	input  wire logic [1:0]       count_mode_select,
	input  wire logic             dir_down,
	input  wire logic [WIDTH-1:0] reload,
	input  wire logic             restart,
	// state
	output logic      [WIDTH-1:0] counter_value,
	output logic                  counting_down,
	output logic                  wrap
);

	logic [WIDTH-1:0] nxt_cnt;
	logic             nxt_down;
	logic             centre;
	logic             at_top;
	logic             at_zero;

	// centre-aligned for any nonzero selection
	assign centre  = (count_mode_select != 2'b00);
	assign at_top  = (counter_value >= reload);
	assign at_zero = (counter_value == '0);

	// next count; edge mode follows the direction bit
	always_comb begin
		nxt_cnt  = counter_value;
		nxt_down = counting_down;
		if (restart) begin
			nxt_cnt  = (dir_down && !centre) ? reload : '0;
			nxt_down = dir_down && !centre;
		end else if (run) begin
			if (centre) begin
				if (!counting_down && at_top) begin
					nxt_down = 1'b1;
					nxt_cnt  = counter_value - 1'b1;
				end else if (counting_down && at_zero) begin
					nxt_down = 1'b0;
					nxt_cnt  = counter_value + 1'b1;
				end else if (counting_down) begin
					nxt_cnt = counter_value - 1'b1;
				end else begin
					nxt_cnt = counter_value + 1'b1;
				end
			end else begin
				nxt_down = dir_down;
				if (dir_down)
					nxt_cnt = at_zero ? reload : counter_value - 1'b1;
				else
					nxt_cnt = at_top ? '0 : counter_value + 1'b1;
			end
		end
	end

	// overflow or underflow marker
	assign wrap = run && !restart &&
		((centre && ((!counting_down && at_top) ||
			(counting_down && at_zero))) ||
		(!centre && (dir_down ? at_zero : at_top)));

	// held still when not running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value <= '0;
			counting_down <= 1'b0;
		end else begin
			counter_value <= nxt_cnt;
			counting_down <= nxt_down;
		end
	end

endmodule

// file: sim/pwo_top_assertions.sv
// pwo_top_assertions.sv: port-level checker for the channel 0 output block.
// assumes: bound to pwo_top, sees only its ports, single pclk domain.
`timescale 1ns/1ps

module pwo_top_assertions (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave side
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// trigger and channel output
	input  wire logic        trig_in,
	input  wire logic        chan0_output_reference
);
	// =================================================================
	// mode shadow
	logic [3:0] mode_ff;
	logic [1:0] age_ff;
	wire        mode_wr;
	wire        out;

	// write to the channel 0 config word lands at the pready edge
	assign mode_wr = psel && penable && pready && pwrite && paddr == 12'h040;
	assign out     = chan0_output_reference;

	// age saturates so the registered output has time to follow a change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= 4'h0;
			age_ff  <= 2'h0;
		end else if (mode_wr) begin
			mode_ff <= {pwdata[8], pwdata[2:0]};
			age_ff  <= 2'h0;
		end else if (age_ff != 2'h3) begin
			age_ff <= age_ff + 2'h1;
		end
	end

	// =================================================================
	// properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_acc_start;
		psel && penable && !pready && !$past(penable);
	endsequence
	sequence s_acc_end;
		psel && penable && pready;
	endsequence

	a_ready_late: assert property (s_acc_start |=> s_acc_end)
		else $error("pready not one cycle after access start");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_err_read: assert property (pslverr |-> pready && (pwrite || prdata == 0))
		else $error("refused access not clean");
	a_force_low: assert property (mode_ff == 4'b0100 && age_ff == 2'h3 |-> !out)
		else $error("forced low output is high");
	a_force_high: assert property (mode_ff == 4'b0101 && age_ff == 2'h3 |-> out)
		else $error("forced high output is low");
	a_match_low: assert property (mode_ff == 4'b0001 && age_ff == 2'h3 && !out |=> !out)
		else $error("drive-low mode left low level");
	a_match_high: assert property (mode_ff == 4'b0010 && age_ff == 2'h3 && out |=> out)
		else $error("drive-high mode left high level");
	a_keep_level: assert property (mode_ff == 4'b0000 && age_ff == 2'h3 |-> $stable(out))
		else $error("no-change mode moved the output");
endmodule

bind pwo_top pwo_top_assertions pwo_top_assertions_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .trig_in(trig_in),
	.chan0_output_reference(chan0_output_reference)
);

// file: sim/testbench.sv
// testbench.sv: self-checking bench for the channel 0 output block.
// assumes: reload set to 15, so one edge-aligned period is 16 cycles.
`timescale 1ns/1ps
`include "pwo_cfg.svh"

module testbench;
	logic        pclk, presetn, psel, penable, pwrite, trig_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, out;
	logic [32:0] exp_q[$];
	logic [15:0] lfsr;
	int          err_count, tests_run;
	int          mtab[6] = '{3, 1, 2, 0, 4, 5};
	int          htab[6] = '{32, 0, 64, 64, 0, 64};
	int          ttab[6] = '{4, 0, 0, 0, 0, 0};

	pwo_top pwo_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trig_in(trig_in),
		.chan0_output_reference(out)
	);

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	// =================================================================
	// helpers
	function automatic logic [15:0] nxt_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		chk_rd(33'(got), 33'(exp));
	endtask

	// one apb transfer; the expected {pslverr, read data} goes to the queue
	task automatic xfer(input logic w, input logic [11:0] a,
			input logic [31:0] d, input logic [32:0] e);
		int n;
		exp_q.push_back(e);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_count++;
			stop_test();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// counts high cycles and level changes over n cycles
	task automatic measure(input int n, output int hi, output int tg);
		logic last;
		last = out;
		hi = 0;
		tg = 0;
		repeat (n) begin
			@(posedge pclk);
			hi += (out === 1'b1);
			tg += (out !== last) || $isunknown(out);
			last = out;
		end
	endtask

	// monitor: every answer is matched to the oldest expectation
	always @(posedge pclk) begin
		if (pready === 1'b1 && exp_q.size() > 0) begin
			chk_rd({pslverr, pwrite ? 32'h0000_0000 : prdata}, exp_q.pop_front());
		end
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		stop_test();
	end

	// =================================================================
	// main sequence
	initial begin
		int hi, tg, cmp, acmp, ev;
		{psel, penable, pwrite, trig_in, presetn} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		lfsr = 16'h0B9F;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(0, `PWO_OFS_CH0OCFG, 32'h0, 33'h0_0000_0000);
		xfer(0, `PWO_OFS_RELOAD, 32'h0, 33'h0_0000_FFFF);
		xfer(1, 12'h0FC, 32'hFFFF_FFFF, 33'h1_0000_0000);
		xfer(0, 12'h0FC, 32'h0, 33'h1_0000_0000);
		xfer(1, `PWO_OFS_CH0OCFG, 32'hFFFF_FFFF, 33'h0);
		xfer(0, `PWO_OFS_CH0OCFG, 32'h0, 33'h0_0000_0137);
		xfer(1, `PWO_OFS_CH0OCFG, 32'h0, 33'h0);
		$display("test registers done");
		xfer(1, `PWO_OFS_RELOAD, 32'h0000_000F, 33'h0);
		repeat (8) @(posedge pclk);
		xfer(0, `PWO_OFS_CNT, 32'h0, 33'h0);
		// single pulse started by the trigger pin, cleared at wrap
		xfer(1, `PWO_OFS_MDCFG, 32'h0100_0000, 33'h0);
		trig_in <= 1'b1;
		repeat (4) @(posedge pclk);
		trig_in <= 1'b0;
		xfer(0, `PWO_OFS_CTRL, 32'h0, 33'h0_0000_0001);
		repeat (40) @(posedge pclk);
		xfer(0, `PWO_OFS_CTRL, 32'h0, 33'h0);
		xfer(1, `PWO_OFS_MDCFG, 32'h0, 33'h0);
		$display("test run control done");
		xfer(1, `PWO_OFS_CTRL, 32'h0000_0001, 33'h0);
		// pwm duty over four whole periods; compare written unbuffered
		for (int i = 0; i < 6; i++) begin
			lfsr = nxt_rand(lfsr);
			cmp = int'(lfsr % 16'h000F) + 1;
			xfer(1, `PWO_OFS_CH0CMP, 32'(cmp), 33'h0);
			xfer(1, `PWO_OFS_CH0OCFG, {30'h0, 2'h3} + 32'(i % 2) + 32'h3,
				33'h0);
			repeat (32) @(posedge pclk);
			measure(64, hi, tg);
			chk_cnt(hi, (i % 2) ? 64 - 4 * cmp : 4 * cmp);
		end
		$display("test pwm done");
		// match actions and forced levels, level and edge counts
		for (int i = 0; i < 6; i++) begin
			xfer(1, `PWO_OFS_CH0OCFG, 32'(mtab[i]), 33'h0);
			repeat (20) @(posedge pclk);
			measure(64, hi, tg);
			chk_cnt(hi, htab[i]);
			chk_cnt(tg, ttab[i]);
		end
		$display("test match modes done");
		// asymmetric pwm on centre-aligned counting, period 30 cycles
		xfer(1, `PWO_OFS_CNTCFG, 32'h0001_0000, 33'h0);
		for (int i = 0; i < 2; i++) begin
			lfsr = nxt_rand(lfsr);
			cmp = int'(lfsr % 16'h000F) + 1;
			acmp = int'((lfsr >> 4) % 16'h000F);
			xfer(1, `PWO_OFS_CH0ACMP, 32'(acmp), 33'h0);
			xfer(0, `PWO_OFS_CH0ACMP, 32'h0, 33'(acmp));
			xfer(1, `PWO_OFS_CH0CMP, 32'(cmp), 33'h0);
			xfer(1, `PWO_OFS_CH0OCFG, 32'h0000_0106 + 32'(i), 33'h0);
			repeat (32) @(posedge pclk);
			measure(60, hi, tg);
			ev = 2 * (cmp + acmp);
			chk_cnt(hi, i ? 60 - ev : ev);
		end
		// edge-aligned down counting: pwm1 high while counter <= compare
		xfer(1, `PWO_OFS_CNTCFG, 32'h0100_0000, 33'h0);
		xfer(1, `PWO_OFS_CH0OCFG, 32'h0000_0006, 33'h0);
		repeat (32) @(posedge pclk);
		measure(64, hi, tg);
		chk_cnt(hi, 4 * (cmp + 1));
		// software trigger forces pwm1 to its matched level until a wrap
		xfer(1, `PWO_OFS_CNTCFG, 32'h0000_0000, 33'h0);
		xfer(1, `PWO_OFS_CH0CMP, 32'h0000_0010, 33'h0);
		xfer(1, `PWO_OFS_CH0OCFG, 32'h0000_0026, 33'h0);
		repeat (20) @(posedge pclk);
		xfer(1, `PWO_OFS_EVGEN, 32'h0000_0004, 33'h0);
		@(posedge pclk);
		chk_rd(33'(out), 33'h0);
		repeat (20) @(posedge pclk);
		measure(16, hi, tg);
		chk_cnt(hi, 16);
		$display("test asymmetric and immediate modes done");
		// preload: a stopped timer never wraps, so the old compare stays
		xfer(1, `PWO_OFS_CTRL, 32'h0, 33'h0);
		xfer(1, `PWO_OFS_CH0OCFG, 32'h0000_0016, 33'h0);
		xfer(1, `PWO_OFS_CH0CMP, 32'(cmp), 33'h0);
		xfer(0, `PWO_OFS_CH0CMP, 32'h0, 33'h0_0000_0010);
		xfer(1, `PWO_OFS_CTRL, 32'h0000_0001, 33'h0);
		repeat (20) @(posedge pclk);
		xfer(0, `PWO_OFS_CH0CMP, 32'h0, 33'(cmp));
		$display("test preload done");
		stop_test();
	end
endmodule
